// ---- verilog/xfd_decode.sv ----
// top: page/config registers, external move decode, fifo window stall
module xfd_decode
#(
  parameter bit LARGE_MEM = 1'b0
)
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // direct-address space port
  input  wire logic        dir_req_i,
  input  wire logic        dir_write_i,
  input  wire logic        dir_bit_i,
  input  wire logic [7:0]  dir_addr_i,
  input  wire logic [7:0]  dir_wdata_i,
  output logic [7:0]       dir_rdata_o,
  output logic             dir_to_sfs_o,
  output logic             dir_bit_ok_o,
  // external move port
  input  wire logic        xm_req_i,
  input  wire logic        xm_write_i,
  input  wire logic        xm_short_i,
  input  wire logic [15:0] xm_addr_i,
  input  wire logic [7:0]  xm_wdata_i,
  output logic [7:0]       xm_rdata_o,
  output logic             xm_ready_o,
  output logic             xm_stall_o,
  output logic             xm_fifo_hit_o,
  output logic [7:0]       page_o,
  output logic             win_en_o
);
  logic [4:0]  page_reg;
  logic [4:0]  page_next;
  logic        en_reg;
  logic        en_next;
  logic [7:0]  on_chip_external_ram [0:(1<<xfd_pkg::ON_CHIP_EXTERNAL_RAM_AW_LARGE)-1];
  logic [15:0] full_addr;
  logic [11:0] xidx;
  logic        hit;
  logic        fifo_done;
  logic [7:0]  fifo_rdata;
  logic        fifo_start;
  logic        cfg_sel;
  logic        pg_sel;
  logic [7:0]  cfg_rd;
  logic [7:0]  pg_rd;
  xfd_pkg::xfd_state_t st_reg;
  xfd_pkg::xfd_state_t st_next;
  logic        on_chip_external_ram_rd_next;

  // decode of direct space and read views
  always_comb
  begin
    cfg_sel = dir_req_i && (dir_addr_i == xfd_pkg::ADDR_MEM_CONFIG);
    pg_sel  = dir_req_i && (dir_addr_i == xfd_pkg::ADDR_PAGE_SELECT);
    cfg_rd  = xfd_pkg::CFG_FIXED;
    cfg_rd[xfd_pkg::CFG_EN_BIT] = en_reg;
    pg_rd   = {3'h0, page_reg};
  end

  // register writes
  always_comb
  begin
    page_next = page_reg;
    en_next   = en_reg;
    if (pg_sel && dir_write_i && !dir_bit_i)
      page_next = dir_wdata_i[xfd_pkg::PAGE_W-1:0];
    if (cfg_sel && dir_write_i)
      en_next = dir_wdata_i[xfd_pkg::CFG_EN_BIT];
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      page_reg <= xfd_pkg::PAGE_RESET;
      en_reg   <= 1'b0;
    end
    else
    begin
      page_reg <= page_next;
      en_reg   <= en_next;
    end
  end

  // direct-port outputs
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dir_rdata_o  <= 8'h00;
      dir_to_sfs_o <= 1'b0;
      dir_bit_ok_o <= 1'b0;
    end
    else
    begin
      dir_to_sfs_o <= dir_req_i && (dir_addr_i >= xfd_pkg::SFS_BASE);
      dir_bit_ok_o <= dir_req_i && (dir_addr_i >= xfd_pkg::SFS_BASE)
                      && ((dir_addr_i[3:0] == xfd_pkg::BIT_NIBBLE_LO)
                      ||  (dir_addr_i[3:0] == xfd_pkg::BIT_NIBBLE_HI));
      dir_rdata_o  <= cfg_sel ? cfg_rd : (pg_sel ? pg_rd : 8'h00);
    end
  end

  // external move address: page byte for short operand, modulo index
  always_comb
  begin
    full_addr = xm_addr_i;
    if (xm_short_i)
      full_addr = {3'h0,
                   page_reg & (LARGE_MEM ? xfd_pkg::PAGE_MASK_LARGE : xfd_pkg::PAGE_MASK_SMALL),
                   xm_addr_i[7:0]};
    hit  = en_reg && (full_addr >= xfd_pkg::WIN_LO)
                  && (full_addr <= xfd_pkg::WIN_HI);
    xidx = full_addr[11:0] & (LARGE_MEM ? xfd_pkg::XMASK_LARGE
                                        : xfd_pkg::XMASK_SMALL);
  end

  // external move sequencing
  always_comb
  begin
    st_next      = st_reg;
    fifo_start   = 1'b0;
    on_chip_external_ram_rd_next = 1'b0;
    unique case (st_reg)
      xfd_pkg::XFD_IDLE:
        if (xm_req_i && hit)
        begin
          fifo_start = 1'b1;
          st_next    = xfd_pkg::XFD_WAIT;
        end
        else if (xm_req_i)
          on_chip_external_ram_rd_next = 1'b1;
      xfd_pkg::XFD_WAIT:
        if (fifo_done)
          st_next = xfd_pkg::XFD_DONE;
      xfd_pkg::XFD_DONE:
        st_next = xfd_pkg::XFD_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg        <= xfd_pkg::XFD_IDLE;
      xm_ready_o    <= 1'b0;
      xm_stall_o    <= 1'b0;
      xm_fifo_hit_o <= 1'b0;
      xm_rdata_o    <= 8'h00;
      page_o        <= 8'h00;
      win_en_o      <= 1'b0;
    end
    else
    begin
      st_reg        <= st_next;
      xm_ready_o    <= on_chip_external_ram_rd_next || (st_reg == xfd_pkg::XFD_WAIT && fifo_done);
      xm_stall_o    <= (st_next == xfd_pkg::XFD_WAIT);
      xm_fifo_hit_o <= fifo_start;
      if (on_chip_external_ram_rd_next)
        xm_rdata_o <= on_chip_external_ram[xidx];
      else if (st_reg == xfd_pkg::XFD_WAIT && fifo_done)
        xm_rdata_o <= fifo_rdata;
      page_o        <= {3'h0, page_next};
      win_en_o      <= en_next;
    end
  end

  // on_chip_external_ram writes, never under an enabled window hit
  always_ff @(posedge clock_i)
  begin
    if (st_reg == xfd_pkg::XFD_IDLE && xm_req_i && xm_write_i && !hit)
      on_chip_external_ram[xidx] <= xm_wdata_i;
  end

  // fifo address window offset via low ten bits
  xfd_fifo_port u_fifo
  (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .start_i (fifo_start),
    .write_i (xm_write_i),
    .addr_i  (full_addr[xfd_pkg::FIFO_AW-1:0]),
    .wdata_i (xm_wdata_i),
    .done_o  (fifo_done),
    .rdata_o (fifo_rdata)
  );

  // window access walk: take, stall while the usb side works, then answer
  sequence seq_win_take;
    st_reg == xfd_pkg::XFD_IDLE && xm_req_i && hit;
  endsequence
  sequence seq_win_stall;
    xm_stall_o [*4];
  endsequence
  sequence seq_move_answer;
    xm_ready_o && !xm_stall_o;
  endsequence
  // plain on_chip_external_ram move: taken on one edge, answered by the next
  sequence seq_on_chip_external_ram_take;
    st_reg == xfd_pkg::XFD_IDLE && xm_req_i && !hit;
  endsequence

  // checks
  chk_page_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (pg_sel && dir_write_i && !dir_bit_i) |=> (page_o == {3'h0, $past(dir_wdata_i[4:0])}))
    else $error("page field not written");
  chk_cfg_fixed: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cfg_sel |=> (dir_rdata_o[5:0] == 6'h03 && !dir_rdata_o[7]))
    else $error("config fixed bits wrong");
  chk_no_fifo_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !win_en_o |-> ##1 !xm_fifo_hit_o) else $error("fifo reached while disabled");
  chk_win_hit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    seq_win_take |=> seq_win_stall) else $error("window hit did not stall");
  chk_win_answer: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    seq_win_take |=> seq_win_stall ##2 seq_move_answer)
    else $error("window answer not on time");
  chk_on_chip_external_ram_fast: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    seq_on_chip_external_ram_take |=> seq_move_answer) else $error("on_chip_external_ram move not answered next cycle");
  chk_stall_end: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(xm_stall_o) |-> ##[1:8] xm_ready_o) else $error("stall never ended");
  chk_sfs_route: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (dir_req_i && dir_addr_i[7]) |=> dir_to_sfs_o) else $error("sfs not routed");
  chk_ram_route: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (dir_req_i && !dir_addr_i[7]) |=> !dir_to_sfs_o) else $error("low address sent to sfs");
  chk_bit_slot: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (dir_req_i && dir_addr_i[7] && dir_addr_i[2:0] == 3'h0) |=> dir_bit_ok_o)
    else $error("bit slot missing");
  chk_en_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cfg_sel && dir_write_i) |=> ##1 (win_en_o == $past(dir_wdata_i[6], 2)))
    else $error("enable bit not written");
endmodule : xfd_decode

// ---- include/xfd_pkg.sv ----
// package: constants and types for the on_chip_external_ram page and fifo window decode
package xfd_pkg;
  localparam logic [7:0]  ADDR_MEM_CONFIG  = 8'h85;
  localparam logic [7:0]  ADDR_PAGE_SELECT = 8'hAA;
  localparam logic [7:0]  SFS_BASE         = 8'h80;
  localparam logic [3:0]  BIT_NIBBLE_LO    = 4'h0;
  localparam logic [3:0]  BIT_NIBBLE_HI    = 4'h8;
  localparam int          PAGE_W           = 5;
  localparam logic [4:0]  PAGE_RESET       = 5'h00;
  localparam logic [4:0]  PAGE_MASK_SMALL  = 5'h07;
  localparam logic [4:0]  PAGE_MASK_LARGE  = 5'h1F;
  localparam int          CFG_EN_BIT       = 6;
  localparam logic [7:0]  CFG_FIXED        = 8'h03;
  localparam logic [15:0] WIN_LO           = 16'h0400;
  localparam logic [15:0] WIN_HI           = 16'h07FF;
  localparam int          FIFO_AW          = 10;
  localparam int          ON_CHIP_EXTERNAL_RAM_AW_SMALL    = 10;
  localparam int          ON_CHIP_EXTERNAL_RAM_AW_LARGE    = 12;
  localparam logic [11:0] XMASK_SMALL      = 12'h3FF;
  localparam logic [11:0] XMASK_LARGE      = 12'hFFF;
  // fifo access latency in core cycles (handshake across the usb domain)
  localparam logic [2:0]  FIFO_WAIT        = 3'h4;
  typedef enum logic [1:0] {XFD_IDLE, XFD_WAIT, XFD_DONE} xfd_state_t;
endpackage : xfd_pkg

// ---- verilog/xfd_fifo_port.sv ----
// fifo RAM port model: usb-domain access modelled as a fixed wait
module xfd_fifo_port
(
  input  wire logic                       clock_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       start_i,
  input  wire logic                       write_i,
  input  wire logic [xfd_pkg::FIFO_AW-1:0] addr_i,
  input  wire logic [7:0]                 wdata_i,
  output logic                            done_o,
  output logic [7:0]                      rdata_o
);
  logic [7:0] mem [0:(1<<xfd_pkg::FIFO_AW)-1];
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic       done_next;
  logic [xfd_pkg::FIFO_AW-1:0] addr_reg;
  logic [xfd_pkg::FIFO_AW-1:0] addr_next;

  // wait counter; longer than an on_chip_external_ram access
  always_comb
  begin
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    addr_next = addr_reg;
    if (start_i)
    begin
      cnt_next  = xfd_pkg::FIFO_WAIT;
      addr_next = addr_i; // word address held while the usb side works
    end
    else if (cnt_reg != 3'h0)
    begin
      cnt_next  = cnt_reg - 3'h1;
      done_next = (cnt_reg == 3'h1);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg  <= 3'h0;
      done_o   <= 1'b0;
      addr_reg <= '0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      done_o   <= done_next;
      addr_reg <= addr_next;
    end
  end

  // storage, usable as general ram
  always_ff @(posedge clock_i)
  begin
    if (start_i && write_i)
      mem[addr_i] <= wdata_i;
    rdata_o <= mem[addr_reg];
  end
endmodule : xfd_fifo_port

// ---- test/xfd_cpu_model.sv ----
// cpu-side model issuing direct and external move requests
module xfd_cpu_model
(
  input  wire logic        clock_i,
  output logic             dir_req_o,
  output logic             dir_write_o,
  output logic             dir_bit_o,
  output logic [7:0]       dir_addr_o,
  output logic [7:0]       dir_wdata_o,
  input  wire logic [7:0]  dir_rdata_i,
  input  wire logic        dir_to_sfs_i,
  input  wire logic        dir_bit_ok_i,
  output logic             xm_req_o,
  output logic             xm_write_o,
  output logic             xm_short_o,
  output logic [15:0]      xm_addr_o,
  output logic [7:0]       xm_wdata_o,
  input  wire logic [7:0]  xm_rdata_i,
  input  wire logic        xm_ready_i,
  input  wire logic        xm_fifo_hit_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero; special addresses used are the decoded 0x85 and 0xAA plus undecoded bit slot 0xA8
  initial
  begin
    {dir_req_o, dir_write_o, dir_bit_o, dir_addr_o, dir_wdata_o} = '0;
    {xm_req_o, xm_write_o, xm_short_o, xm_addr_o, xm_wdata_o} = '0;
  end
  // direct access: one-cycle strobe, answer stands for the cycle after the take edge
  task automatic dir_acc(input logic w, input logic b, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic sfs, output logic bok);
    @(posedge clock_i);
    dir_req_o   <= 1'b1;
    dir_write_o <= w;
    dir_bit_o   <= b;
    dir_addr_o  <= a;
    dir_wdata_o <= d;
    @(posedge clock_i);
    dir_req_o   <= 1'b0;
    dir_addr_o  <= ~a;
    dir_wdata_o <= ~d;
    @(negedge clock_i);
    q   = dir_rdata_i;
    sfs = dir_to_sfs_i;
    bok = dir_bit_ok_i;
  endtask : dir_acc
  // external move; fifo data used as scratch only, usb clock fast
  // request and qualifiers stand until the first rising edge after ready is seen high
  task automatic xm_acc(input logic w, input logic s, input logic [15:0] a,
    input logic [7:0] d, output logic [7:0] q, output int n, output logic hit);
    n = 1;
    @(posedge clock_i);
    xm_req_o   <= 1'b1;
    xm_write_o <= w;
    xm_short_o <= s;
    xm_addr_o  <= a;
    xm_wdata_o <= d;
    @(posedge clock_i);
    @(negedge clock_i);
    hit = xm_fifo_hit_i;
    while (n < 20 && xm_ready_i !== 1'b1)
    begin
      @(negedge clock_i);
      n   = n + 1;
      hit = hit | xm_fifo_hit_i;
    end
    q = xm_rdata_i;
    @(posedge clock_i);
    xm_req_o   <= 1'b0;
    xm_addr_o  <= ~a;
    xm_wdata_o <= ~d;
  endtask : xm_acc
endmodule : xfd_cpu_model

// ---- test/xfd_decode_tb_top.sv ----
// testbench: register, decode and fifo window sequences
module xfd_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i, rst_n_i, dir_req, dir_write, dir_bit, dir_to_sfs, dir_bit_ok;
  logic [7:0]  dir_addr, dir_wdata, dir_rdata, xm_wdata, xm_rdata, page, q;
  logic        xm_req, xm_write, xm_short, xm_ready, xm_stall, xm_hit, win_en;
  logic [15:0] xm_addr;
  logic        sfs, bok, hit;
  int          n, fails, compares, cycles, stalls;
  xfd_decode u_xfd_decode (.clock_i(clock_i), .rst_n_i(rst_n_i), .dir_req_i(dir_req),
    .dir_write_i(dir_write), .dir_bit_i(dir_bit), .dir_addr_i(dir_addr),
    .dir_wdata_i(dir_wdata), .dir_rdata_o(dir_rdata), .dir_to_sfs_o(dir_to_sfs),
    .dir_bit_ok_o(dir_bit_ok), .xm_req_i(xm_req), .xm_write_i(xm_write),
    .xm_short_i(xm_short), .xm_addr_i(xm_addr), .xm_wdata_i(xm_wdata),
    .xm_rdata_o(xm_rdata), .xm_ready_o(xm_ready), .xm_stall_o(xm_stall),
    .xm_fifo_hit_o(xm_hit), .page_o(page), .win_en_o(win_en));
  xfd_cpu_model u_xfd_cpu_model (.clock_i(clock_i), .dir_req_o(dir_req),
    .dir_write_o(dir_write), .dir_bit_o(dir_bit), .dir_addr_o(dir_addr),
    .dir_wdata_o(dir_wdata), .dir_rdata_i(dir_rdata), .dir_to_sfs_i(dir_to_sfs),
    .dir_bit_ok_i(dir_bit_ok), .xm_req_o(xm_req), .xm_write_o(xm_write),
    .xm_short_o(xm_short), .xm_addr_o(xm_addr), .xm_wdata_o(xm_wdata),
    .xm_rdata_i(xm_rdata), .xm_ready_i(xm_ready), .xm_fifo_hit_i(xm_hit));
  // 250 MHz core clock
  initial clock_i = 1'b0;
  always #2 clock_i = ~clock_i;
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic d(input logic w, input logic b, input logic [7:0] a, input logic [7:0] wd);
    u_xfd_cpu_model.dir_acc(w, b, a, wd, q, sfs, bok);
  endtask : d
  task automatic x(input logic w, input logic s, input logic [15:0] a, input logic [7:0] wd);
    u_xfd_cpu_model.xm_acc(w, s, a, wd, q, n, hit);
  endtask : x
  // hang guard
  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fails = fails + 1;
      tally_and_finish();
    end
  end
  // core cycles spent stalled, counted where the stall output is settled
  always @(negedge clock_i)
    if (xm_stall === 1'b1)
      stalls <= stalls + 1;
  // main sequence
  initial
  begin
    {fails, compares, cycles, stalls} = '0;
    rst_n_i = 1'b0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1;
    check(page, 16'h0000);
    check(win_en, 16'h0000);
    d(0, 0, 8'h85, 8'h00);
    check(q, 16'h0003);
    d(1, 0, 8'hAA, 8'hFF);
    check(page, 16'h001F);
    d(0, 0, 8'hAA, 8'h00);
    check(q, 16'h001F);
    check(sfs, 16'h0001);
    d(0, 1, 8'hA8, 8'h00);
    check(bok, 16'h0001);
    d(0, 1, 8'hAA, 8'h00);
    check(bok, 16'h0000);
    d(0, 0, 8'h30, 8'h00);
    check(sfs, 16'h0000);
    d(1, 0, 8'hAA, 8'h01);
    x(1, 0, 16'h0123, 8'h5A);
    x(1, 0, 16'h0023, 8'h11);
    x(0, 0, 16'h0523, 8'h00);
    check(q, 16'h005A);
    check(n, 16'h0001);
    x(0, 1, 16'hEE23, 8'h00);
    check(q, 16'h005A);
    d(1, 0, 8'h85, 8'hFF);
    d(0, 0, 8'h85, 8'h00);
    check(q, 16'h0043);
    check(win_en, 16'h0001);
    x(1, 0, 16'h0423, 8'hC3);
    check(hit, 16'h0001);
    check(n, 16'h0006);
    check(stalls, 16'h0005);
    x(0, 0, 16'h0423, 8'h00);
    check(q, 16'h00C3);
    d(1, 0, 8'hAA, 8'h0C);
    x(0, 1, 16'h0023, 8'h00);
    check(q, 16'h00C3);
    check(hit, 16'h0001);
    check(stalls, 16'h000F);
    x(0, 0, 16'h0023, 8'h00);
    check(q, 16'h0011);
    check(hit, 16'h0000);
    d(1, 0, 8'h85, 8'h00);
    x(0, 0, 16'h0423, 8'h00);
    check(q, 16'h0011);
    check(hit, 16'h0000);
    tally_and_finish();
  end
endmodule : xfd_decode_tb_top
